// ==== src/conv_pkg.sv ====
package conv_pkg;
    localparam int DATA_W = 8;
    localparam int CODE_W = 12;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_C0_LOW = 8'hf9;
    localparam logic [7:0] ADDR_C0_HIGH = 8'hfa;
    localparam logic [7:0] ADDR_C1_LOW = 8'hfb;
    localparam logic [7:0] ADDR_C1_HIGH = 8'hfc;
    localparam logic [7:0] ADDR_CONTROL = 8'hfd;
    localparam logic [7:0] CONTROL_RESET = 8'h04;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int BIT_MODE8 = 7;
    localparam int BIT_RANGE_1 = 6;
    localparam int BIT_RANGE_0 = 5;
    localparam int BIT_ZERO_N_1 = 4;
    localparam int BIT_ZERO_N_0 = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_POWER_1 = 1;
    localparam int BIT_POWER_0 = 0;
    localparam logic [3:0] HIGH_NIBBLE_MASK = 4'hf;
endpackage : conv_pkg

// ==== src/dual_dac_control_regs.sv ====
// Operation
// R01 - Bit 7 high selects 8-bit mode
// R02 - Bit 6 selects converter 1 range
// R03 - Bit 5 selects converter 0 range
// R04 - Bits 4,3 low force outputs zero
// R05 - Bit 2 immediate update, else held
// R06 - Bits 1,0 power converters on
// R07 - Low register write updates output
// R08 - Software writes codes right-justified
// R09 - Four data registers, reset zero
// R10 - Control resets 04H, converters off
// R11 - Reads return last written values
`timescale 1ns/100ps
`default_nettype none
module dual_dac_control_regs
    import conv_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_hit,
    output logic [CODE_W-1:0] conv0_code,
    output logic [CODE_W-1:0] conv1_code,
    output logic range_sel_0,
    output logic range_sel_1,
    output logic zero_force_n_0,
    output logic zero_force_n_1,
    output logic power_on_0,
    output logic power_on_1
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] c0l_q;
    logic [7:0] c0l_d;
    logic [7:0] c0h_q;
    logic [7:0] c0h_d;
    logic [7:0] c1l_q;
    logic [7:0] c1l_d;
    logic [7:0] c1h_q;
    logic [7:0] c1h_d;
    logic [CODE_W-1:0] code0_q;
    logic [CODE_W-1:0] code0_d;
    logic [CODE_W-1:0] code1_q;
    logic [CODE_W-1:0] code1_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic hit_d;
    logic range_1_q;
    logic range_0_q;
    logic zero_n_1_q;
    logic zero_n_0_q;
    logic power_1_q;
    logic power_0_q;
    logic range_1_d;
    logic range_0_d;
    logic zero_n_1_d;
    logic zero_n_0_d;
    logic power_1_d;
    logic power_0_d;
    logic wr_c0l;
    logic wr_c0h;
    logic wr_c1l;
    logic wr_c1h;
    logic wr_ctl;
    logic rd_c0l;
    logic rd_c0h;
    logic rd_c1l;
    logic rd_c1h;
    logic rd_ctl;
    logic rd_any;
    logic mode8_sel;
    logic sync_on;
    logic sync_req;
    logic sync_rise;
    logic upd0;
    logic upd1;

    function automatic logic addr_is(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        addr_is = (addr == target);
    endfunction : addr_is

    // Read lanes are ORed, so at most one select may be high
    function automatic logic [7:0] lane(
        input logic sel,
        input logic [7:0] value
    );
        lane = {8{sel}} & value;
    endfunction : lane

    // 8-bit codes are left-aligned so full scale stays full scale
    function automatic logic [CODE_W-1:0] form_code(
        input logic mode8,
        input logic [7:0] low,
        input logic [7:0] high
    );
        if (mode8) begin
            form_code = {low, 4'h0}; // [R01]
        end else begin
            form_code = {high[3:0] & HIGH_NIBBLE_MASK, low}; // [R08]
        end
    endfunction : form_code

    assign wr_c0l = reg_write && addr_is(reg_addr, ADDR_C0_LOW);
    assign wr_c0h = reg_write && addr_is(reg_addr, ADDR_C0_HIGH);
    assign wr_c1l = reg_write && addr_is(reg_addr, ADDR_C1_LOW);
    assign wr_c1h = reg_write && addr_is(reg_addr, ADDR_C1_HIGH);
    assign wr_ctl = reg_write && addr_is(reg_addr, ADDR_CONTROL);

    assign rd_c0l = reg_read && addr_is(reg_addr, ADDR_C0_LOW);
    assign rd_c0h = reg_read && addr_is(reg_addr, ADDR_C0_HIGH);
    assign rd_c1l = reg_read && addr_is(reg_addr, ADDR_C1_LOW);
    assign rd_c1h = reg_read && addr_is(reg_addr, ADDR_C1_HIGH);
    assign rd_ctl = reg_read && addr_is(reg_addr, ADDR_CONTROL);
    assign rd_any = rd_c0l || rd_c0h || rd_c1l || rd_c1h || rd_ctl;

    // Register values as they stand after this cycle's write
    assign ctrl_d = wr_ctl ? reg_wdata : ctrl_q;
    assign c0l_d = wr_c0l ? reg_wdata : c0l_q; // [R09]
    assign c0h_d = wr_c0h ? reg_wdata : c0h_q; // [R09]
    assign c1l_d = wr_c1l ? reg_wdata : c1l_q; // [R09]
    assign c1h_d = wr_c1h ? reg_wdata : c1h_q; // [R09]

    assign mode8_sel = ctrl_d[BIT_MODE8]; // [R01]
    assign sync_on = ctrl_q[BIT_SYNC];
    assign sync_req = reg_wdata[BIT_SYNC];
    // Only the 0 to 1 change releases held writes; staying 1 does not
    assign sync_rise = wr_ctl && !sync_on && sync_req; // [R05]
    assign upd0 = (sync_on && wr_c0l) || sync_rise; // [R05] [R07]
    assign upd1 = (sync_on && wr_c1l) || sync_rise; // [R05] [R07]

    assign code0_d = upd0 ? form_code(mode8_sel, c0l_d, c0h_d) : code0_q;
    assign code1_d = upd1 ? form_code(mode8_sel, c1l_d, c1h_d) : code1_q;

    assign range_1_d = ctrl_d[BIT_RANGE_1]; // [R02]
    assign range_0_d = ctrl_d[BIT_RANGE_0]; // [R03]
    assign zero_n_1_d = ctrl_d[BIT_ZERO_N_1]; // [R04]
    assign zero_n_0_d = ctrl_d[BIT_ZERO_N_0]; // [R04]
    assign power_1_d = ctrl_d[BIT_POWER_1]; // [R06]
    assign power_0_d = ctrl_d[BIT_POWER_0]; // [R06]

    // Reads are side-effect free
    assign rdata_d = lane(rd_c0l, c0l_q)
        | lane(rd_c0h, c0h_q)
        | lane(rd_c1l, c1l_q)
        | lane(rd_c1h, c1h_q)
        | lane(rd_ctl, ctrl_q); // [R11]
    assign hit_d = rd_any; // [R11]

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= CONTROL_RESET; // [R10]
        end
        else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            c0l_q <= DATA_RESET; // [R09]
        end
        else begin
            c0l_q <= c0l_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            c0h_q <= DATA_RESET; // [R09]
        end
        else begin
            c0h_q <= c0h_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            c1l_q <= DATA_RESET; // [R09]
        end
        else begin
            c1l_q <= c1l_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            c1h_q <= DATA_RESET; // [R09]
        end
        else begin
            c1h_q <= c1h_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            code0_q <= '0;
        end
        else begin
            code0_q <= code0_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            code1_q <= '0;
        end
        else begin
            code1_q <= code1_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= DATA_RESET;
        end
        else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            hit_q <= 1'b0;
        end
        else begin
            hit_q <= hit_d;
        end
    end

    // Control outputs get their own flops so pins never see decode logic
    always_ff @(posedge clock) begin
        if (reset) begin
            range_1_q <= CONTROL_RESET[BIT_RANGE_1]; // [R10]
        end
        else begin
            range_1_q <= range_1_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            range_0_q <= CONTROL_RESET[BIT_RANGE_0]; // [R10]
        end
        else begin
            range_0_q <= range_0_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            zero_n_1_q <= CONTROL_RESET[BIT_ZERO_N_1]; // [R10]
        end
        else begin
            zero_n_1_q <= zero_n_1_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            zero_n_0_q <= CONTROL_RESET[BIT_ZERO_N_0]; // [R10]
        end
        else begin
            zero_n_0_q <= zero_n_0_d;
        end
    end

    // Off after reset: converter outputs float until enabled
    always_ff @(posedge clock) begin
        if (reset) begin
            power_1_q <= CONTROL_RESET[BIT_POWER_1]; // [R10]
        end
        else begin
            power_1_q <= power_1_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            power_0_q <= CONTROL_RESET[BIT_POWER_0]; // [R10]
        end
        else begin
            power_0_q <= power_0_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit = hit_q;
    assign conv0_code = code0_q;
    assign conv1_code = code1_q;
    assign range_sel_1 = range_1_q; // [R02]
    assign range_sel_0 = range_0_q; // [R03]
    assign zero_force_n_1 = zero_n_1_q; // [R04]
    assign zero_force_n_0 = zero_n_0_q; // [R04]
    assign power_on_1 = power_1_q; // [R06]
    assign power_on_0 = power_0_q; // [R06]
endmodule : dual_dac_control_regs
`default_nettype wire

// ==== tb/conv_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module conv_core_model (
    input wire logic [11:0] code,
    input wire logic zero_n,
    input wire logic power,
    output logic [11:0] level
);
    // Off output floats; the board pull-down holds it at ground
    assign level = (power && zero_n) ? code : 12'h000;
endmodule : conv_core_model
`default_nettype wire

// ==== tb/dual_dac_control_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module dual_dac_control_regs_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_hit,
    input wire logic [11:0] conv0_code,
    input wire logic range_sel_0,
    input wire logic zero_force_n_0,
    input wire logic power_on_0
);
    logic [7:0] ctl_q;
    always_ff @(posedge clock)
        if (reset) ctl_q <= 8'h04;
        else if (reg_write && reg_addr == 8'hfd) ctl_q <= reg_wdata;
    default clocking @(posedge clock); endclocking
    default disable iff reset;
    sequence s_lo; reg_write && reg_addr == 8'hf9; endsequence
    property p_rst; $fell(reset) |-> !power_on_0 && conv0_code == 12'h000; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_pwr; power_on_0 == ctl_q[0]; endproperty
    a_pwr: assert property (p_pwr) else $error("power");
    property p_imm; s_lo ##0 ctl_q[2] && !ctl_q[7]
        |=> conv0_code[7:0] == $past(reg_wdata); endproperty
    a_imm: assert property (p_imm) else $error("update");
    property p_hold; s_lo ##0 !ctl_q[2] |=> $stable(conv0_code); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    sequence s_rd_ctl; reg_read && reg_addr == 8'hfd; endsequence
    property p_rng; range_sel_0 == ctl_q[5]; endproperty
    a_rng: assert property (p_rng) else $error("range");
    property p_zero; zero_force_n_0 == ctl_q[3]; endproperty
    a_zero: assert property (p_zero) else $error("clear");
    property p_hit; s_rd_ctl |=> reg_hit; endproperty
    a_hit: assert property (p_hit) else $error("read hit");
endmodule : dual_dac_control_regs_properties
`default_nettype wire

// ==== tb/dual_dac_control_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module dual_dac_control_regs_tb;
    logic clock, reset, reg_write, reg_read, reg_hit, range_sel_0, range_sel_1;
    logic zero_force_n_0, zero_force_n_1, power_on_0, power_on_1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [11:0] conv0_code, conv1_code, level0, level1;
    int err_total = 0, checks = 0;
    dual_dac_control_regs uut (.*);
    conv_core_model core0 (.code(conv0_code), .zero_n(zero_force_n_0),
        .power(power_on_0), .level(level0));
    conv_core_model core1 (.code(conv1_code), .zero_n(zero_force_n_1),
        .power(power_on_1), .level(level1));
    initial forever #20 clock = ~clock;
    task automatic chk(string n, logic [11:0] s, e);
        checks++;
        err_total += int'(s !== e);
        if (s !== e) $display("[ERR] %s exp %h got %h", n, e, s);
    endtask : chk
    task automatic wr(logic [7:0] a, d);
        @(negedge clock) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(negedge clock) reg_write = 0;
    endtask : wr
    task automatic rd(logic [7:0] a, e);
        @(negedge clock) {reg_addr, reg_read} = {a, 1'b1};
        @(negedge clock) reg_read = 0;
        chk("rd", {3'h0, reg_hit, reg_rdata}, {3'h0, a != 8'hf8, e});
    endtask : rd
    task automatic t_imm;
        chk("rst", {6'h00, range_sel_1, range_sel_0, zero_force_n_1,
            zero_force_n_0, power_on_1, power_on_0}, 12'h000);
        rd(8'hfd, 8'h04);
        rd(8'hf8, 8'h00);
        wr(8'hfd, 8'h7f);
        chk("on", {6'h00, range_sel_1, range_sel_0, zero_force_n_1,
            zero_force_n_0, power_on_1, power_on_0}, 12'h03f);
        wr(8'hfa, 8'h35);
        wr(8'hf9, 8'hab);
        chk("c0", level0, 12'h5ab);
        rd(8'hfa, 8'h35);
    endtask : t_imm
    task automatic t_sync;
        wr(8'hfd, 8'hfb);
        wr(8'hfb, 8'hcd);
        wr(8'hf9, 8'h12);
        chk("held", conv1_code, 12'h000);
        chk("held0", conv0_code, 12'h5ab);
        wr(8'hfd, 8'hff);
        chk("c1", conv1_code, 12'hcd0);
        chk("c0", conv0_code, 12'h120);
        chk("lv1", level1, 12'hcd0);
        wr(8'hfd, 8'hf7);
        chk("clr", level0, 12'h000);
        chk("ctl", {6'h00, range_sel_1, range_sel_0, zero_force_n_1,
            zero_force_n_0, power_on_1, power_on_0}, 12'h03b);
        wr(8'hfd, 8'hd6);
        chk("ctl2", {6'h00, range_sel_1, range_sel_0, zero_force_n_1,
            zero_force_n_0, power_on_1, power_on_0}, 12'h02a);
        chk("off", level0, 12'h000);
    endtask : t_sync
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        #20000 err_total++;
        close_out;
    end
    initial begin
        {clock, reset, reg_write, reg_read, reg_addr, reg_wdata} = 20'h40000;
        repeat (8) @(negedge clock);
        reset = 0;
        t_imm;
        t_sync;
        close_out;
    end
endmodule : dual_dac_control_regs_tb
bind dual_dac_control_regs dual_dac_control_regs_properties props (.*);
`default_nettype wire
